// [rtl/efo_defines.svh]
// Purpose: constants of the encoder simulation frequency output unit
// Assumes: 200 MHz core clock, 32-bit APB register window
// Notes:   offsets are byte addresses
`ifndef EFO_DEFINES_SVH
`define EFO_DEFINES_SVH

// register byte offsets
`define EFO_CTRL_OFS     12'h000
`define EFO_MAXSPD_OFS   12'h004
`define EFO_OFFSET_OFS   12'h008
`define EFO_STATUS_OFS   12'h00C
`define EFO_POS_OFS      12'h010

// control register fields
`define EFO_CTRL_SEL_LSB 0
`define EFO_CTRL_SEL_MSB 2
`define EFO_CTRL_ENC_LSB 4
`define EFO_CTRL_ENC_MSB 6

// reset values
`define EFO_SEL_RST      3'h0
`define EFO_ENC_RST      3'h3
`define EFO_MAXSPD_RST   16'h0BB8
`define EFO_OFFSET_RST   16'h0000

// encoder constant code to increments per revolution
`define EFO_INCR_CODE0   13'h0100
`define EFO_INCR_CODE1   13'h0200
`define EFO_INCR_CODE2   13'h0400
`define EFO_INCR_CODE3   13'h0800
`define EFO_INCR_CODE4   13'h1000

// timing and scaling
`define EFO_CLK_HZ       200000000
`define EFO_PCT_SCALE    10000
`define EFO_SEC_PER_MIN  60
`define EFO_RATE_SCALE   600000
`define EFO_QUAD_STATES  4
`define EFO_OFFSET_BITS  16

`endif

// [rtl/efo_pkg.sv]
// Purpose: types of the encoder simulation frequency output unit
// Assumes: nothing beyond the defines header
// Notes:   mode order follows the source selector encoding
package efo_pkg;

  typedef enum logic [2:0] {
    EFO_PERCENT,
    EFO_SPEED,
    EFO_RES_INT,
    EFO_RES_EXT,
    EFO_PASS_ENC,
    EFO_PASS_FREQ,
    EFO_IDLE_A,
    EFO_IDLE_B
  } efo_mode_t;

endpackage

// [rtl/efo_frequency_output_unit.sv]
// Purpose: quadrature pulse output synthesised from setpoints, resolver or pass-through
// Assumes: setpoints, arm and resolver angle come from logic on core_clk
// Notes:   pins pass two flip-flops; APB answers with zero wait states
// Contract
// - mode 0: percent times increments times nmax
// - encoder constant code selects increments; 3=2048
// - armed probe edge: zero one revolution later
// - zero offset shifts; 65536 equals 360 degrees
// - mode 1: rpm times increments over 60
// - modes 2,3: simulate encoder from resolver
// - mode 2: zero at resolver zero plus offset
// - mode 3: zero from armed probe edge
// - mode 4: encoder input passed straight through
// - mode 5: frequency input passed straight through
// - pass-through zero only if input has zero
// - tracks A, B, zero and complements, quadrature
// - positive: A leads B; negative: B leads
`include "efo_defines.svh"
`timescale 1ns/1ps

module efo_frequency_output_unit
  import efo_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] percent_setpoint_in,
  input  wire logic [15:0] speed_setpoint_in,
  input  wire logic        zero_pulse_arm,
  input  wire logic [15:0] resolver_angle,
  input  wire logic        probe_terminal,
  input  wire logic [2:0]  encoder_input_terminal,
  input  wire logic [2:0]  frequency_input_terminal,
  output logic             track_a,
  output logic             track_a_n,
  output logic             track_b,
  output logic             track_b_n,
  output logic             zero_track,
  output logic             zero_track_n
);

  localparam logic [48:0] ACC_MOD =
    49'(64'(`EFO_CLK_HZ) * 64'(`EFO_RATE_SCALE));

  function automatic logic [12:0] incr_for_code(input logic [2:0] code);
    logic [12:0] r;
    r = `EFO_INCR_CODE3;
    unique case (code)
      3'h0:    r = `EFO_INCR_CODE0;
      3'h1:    r = `EFO_INCR_CODE1;
      3'h2:    r = `EFO_INCR_CODE2;
      3'h3:    r = `EFO_INCR_CODE3;
      default: r = `EFO_INCR_CODE4;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] magnitude(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  // configuration registers
  logic [2:0]  output_source_select;
  logic [2:0]  encoder_constant;
  logic [15:0] max_speed_setting;
  logic [15:0] zero_pulse_offset;

  // synchronisers for pins
  logic        probe_meta;
  logic        probe_sync;
  logic        probe_prev;
  logic [2:0]  enc_meta;
  logic [2:0]  enc_sync;
  logic [2:0]  freq_meta;
  logic [2:0]  freq_sync;

  // synthesis state
  efo_mode_t   mode;
  logic [12:0] incr_per_rev;
  logic [15:0] steps_per_rev;
  logic [15:0] offset_steps;
  logic [48:0] rate;
  logic        rate_neg;
  logic [48:0] acc;
  logic        acc_step;
  logic        step_up;
  logic        step_down;
  logic [15:0] pos;
  logic [15:0] res_target;
  logic [15:0] res_diff;
  logic        synced;
  logic        wrapped;
  logic        zero_hit;
  efo_mode_t   mode_prev;
  logic [15:0] zero_ref;
  logic [15:0] zero_pos;
  logic [16:0] travel;

  wire logic apb_write = psel & penable & pwrite;
  wire logic probe_rise = probe_sync & ~probe_prev;

  assign mode          = efo_mode_t'(output_source_select);
  assign incr_per_rev  = incr_for_code(encoder_constant);
  assign steps_per_rev = 16'(incr_per_rev) * 16'(`EFO_QUAD_STATES);

  // zero position in quadrature steps; 2^16 offset counts span one revolution
  always_comb begin
    logic [31:0] prod;
    prod = 32'(zero_pulse_offset) * 32'(steps_per_rev);
    offset_steps = prod[31:`EFO_OFFSET_BITS];
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      output_source_select <= `EFO_SEL_RST;
      encoder_constant     <= `EFO_ENC_RST;
      max_speed_setting    <= `EFO_MAXSPD_RST;
      zero_pulse_offset    <= `EFO_OFFSET_RST;
    end else if (apb_write) begin
      unique case (paddr)
        `EFO_CTRL_OFS: begin
          output_source_select <= pwdata[`EFO_CTRL_SEL_MSB:`EFO_CTRL_SEL_LSB];
          encoder_constant     <= pwdata[`EFO_CTRL_ENC_MSB:`EFO_CTRL_ENC_LSB];
        end
        `EFO_MAXSPD_OFS: max_speed_setting <= pwdata[15:0];
        `EFO_OFFSET_OFS: zero_pulse_offset <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // register reads and bus answer; unmapped addresses give an error and zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable) begin
        unique case (paddr)
          `EFO_CTRL_OFS:
            prdata <= {25'h0, encoder_constant, 1'b0, output_source_select};
          `EFO_MAXSPD_OFS: prdata <= {16'h0, max_speed_setting};
          `EFO_OFFSET_OFS: prdata <= {16'h0, zero_pulse_offset};
          `EFO_STATUS_OFS: prdata <= {28'h0, rate_neg, wrapped, synced, zero_hit};
          `EFO_POS_OFS:    prdata <= {16'h0, pos};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      probe_meta <= 1'b0;
      probe_sync <= 1'b0;
      probe_prev <= 1'b0;
      enc_meta   <= 3'h0;
      enc_sync   <= 3'h0;
      freq_meta  <= 3'h0;
      freq_sync  <= 3'h0;
    end else begin
      probe_meta <= probe_terminal;
      probe_sync <= probe_meta;
      probe_prev <= probe_sync;
      enc_meta   <= encoder_input_terminal;
      enc_sync   <= enc_meta;
      freq_meta  <= frequency_input_terminal;
      freq_sync  <= freq_meta;
    end
  end

  // rate in quadrature transitions, scaled by clock rate times 600000
  always_ff @(posedge core_clk) begin
    logic [48:0] num;
    num = 49'h0;
    if (rst) begin
      rate     <= 49'h0;
      rate_neg <= 1'b0;
    end else begin
      unique case (mode)
        EFO_PERCENT: begin
          // percent in 0.01 % units: f*600000 = pct*incr*nmax
          num = 49'(magnitude(percent_setpoint_in)) * 49'(incr_per_rev)
              * 49'(max_speed_setting) * 49'(`EFO_QUAD_STATES);
          rate_neg <= percent_setpoint_in[15];
        end
        EFO_SPEED: begin
          num = 49'(magnitude(speed_setpoint_in)) * 49'(incr_per_rev)
              * 49'(`EFO_PCT_SCALE) * 49'(`EFO_QUAD_STATES);
          rate_neg <= speed_setpoint_in[15];
        end
        default: rate_neg <= 1'b0;
      endcase
      // clamp keeps at most one transition per clock
      rate <= (num >= ACC_MOD) ? ACC_MOD - 49'h1 : num;
    end
  end

  // phase accumulator; each overflow is one quadrature transition
  always_ff @(posedge core_clk) begin
    logic [48:0] sum;
    sum = acc + rate;
    if (rst) begin
      acc      <= 49'h0;
      acc_step <= 1'b0;
    end else if (sum >= ACC_MOD) begin
      acc      <= sum - ACC_MOD;
      acc_step <= 1'b1;
    end else begin
      acc      <= sum;
      acc_step <= 1'b0;
    end
  end

  // resolver angle mapped onto output steps; chase it one step per clock
  always_comb begin
    logic [31:0] prod;
    prod = 32'(resolver_angle) * 32'(steps_per_rev);
    res_target = prod[31:16];
    if (res_target >= pos) begin
      res_diff = res_target - pos;
    end else begin
      res_diff = res_target + steps_per_rev - pos;
    end
  end

  always_comb begin
    step_up   = 1'b0;
    step_down = 1'b0;
    unique case (mode)
      EFO_PERCENT, EFO_SPEED: begin
        step_up   = acc_step & ~rate_neg;
        step_down = acc_step & rate_neg;
      end
      EFO_RES_INT, EFO_RES_EXT: begin
        step_up   = (res_diff != 16'h0) & (res_diff < {1'b0, steps_per_rev[15:1]});
        step_down = (res_diff != 16'h0) & ~step_up;
      end
      default: ;
    endcase
  end

  // position within one revolution of output steps
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos <= 16'h0;
    end else if (pos >= steps_per_rev) begin
      pos <= 16'h0;
    end else if (step_up) begin
      pos <= (pos == steps_per_rev - 16'h1) ? 16'h0 : pos + 16'h1;
    end else if (step_down) begin
      pos <= (pos == 16'h0) ? steps_per_rev - 16'h1 : pos - 16'h1;
    end
  end

  // external zero reference: the armed probe edge marks the start position and
  // the first zero follows one full revolution of travel, in either direction;
  // the probe edge never jumps pos, so the tracks keep strict quadrature
  always_ff @(posedge core_clk) begin
    logic [16:0] delta;
    delta = step_up ? 17'h00001 : (step_down ? 17'h1FFFF : 17'h00000);
    if (rst) begin
      synced    <= 1'b0;
      wrapped   <= 1'b0;
      travel    <= 17'h00000;
      zero_ref  <= 16'h0000;
      mode_prev <= EFO_PERCENT;
    end else begin
      mode_prev <= mode;
      // the probe wins over a mode change in the same cycle
      if (probe_rise & zero_pulse_arm
          & (mode == EFO_PERCENT || mode == EFO_SPEED || mode == EFO_RES_EXT)) begin
        synced   <= 1'b1;
        wrapped  <= 1'b0;
        travel   <= delta;
        zero_ref <= pos;
      end else if (mode != mode_prev) begin
        synced  <= 1'b0;
        wrapped <= 1'b0;
      end else if (synced & ~wrapped) begin
        travel <= travel + delta;
        if (travel + delta == {1'b0, steps_per_rev}
            || travel + delta == 17'h00000 - {1'b0, steps_per_rev}) begin
          wrapped <= 1'b1;
        end
      end
    end
  end

  // synced zero position: start mark plus offset, folded into one revolution
  always_comb begin
    logic [16:0] sum;
    sum      = {1'b0, zero_ref} + {1'b0, offset_steps};
    zero_pos = (sum >= {1'b0, steps_per_rev}) ? 16'(sum - {1'b0, steps_per_rev}) : sum[15:0];
  end

  always_comb begin
    zero_hit = 1'b0;
    unique case (mode)
      EFO_RES_INT: zero_hit = (pos == offset_steps);
      EFO_PERCENT, EFO_SPEED, EFO_RES_EXT:
        zero_hit = synced & wrapped & (pos == zero_pos);
      default: ;
    endcase
  end

  // output stage; A leads B when counting up
  always_ff @(posedge core_clk) begin
    logic a;
    logic b;
    logic z;
    a = pos[1] ^ pos[0];
    b = pos[1];
    z = zero_hit;
    unique case (mode)
      EFO_PASS_ENC: begin
        a = enc_sync[0];
        b = enc_sync[1];
        z = enc_sync[2];
      end
      EFO_PASS_FREQ: begin
        a = freq_sync[0];
        b = freq_sync[1];
        z = freq_sync[2];
      end
      default: ;
    endcase
    if (rst) begin
      track_a      <= 1'b0;
      track_a_n    <= 1'b1;
      track_b      <= 1'b0;
      track_b_n    <= 1'b1;
      zero_track   <= 1'b0;
      zero_track_n <= 1'b1;
    end else begin
      track_a      <= a;
      track_a_n    <= ~a;
      track_b      <= b;
      track_b_n    <= ~b;
      zero_track   <= z;
      zero_track_n <= ~z;
    end
  end

endmodule // efo_frequency_output_unit

// [verification/efo_props.sv]
// Purpose: port checker for the frequency output unit
// Assumes: one clock, synchronous reset
// Notes: source mode is tracked from control register writes
`timescale 1ns/1ps
module efo_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  encoder_input_terminal,
  input wire logic [2:0]  frequency_input_terminal,
  input wire logic        track_a,
  input wire logic        track_a_n,
  input wire logic        track_b,
  input wire logic        track_b_n,
  input wire logic        zero_track,
  input wire logic        zero_track_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [2:0] mode;
  logic [2:0] held;
  logic       setup;
  logic       ctrl_wr;
  assign setup = psel && !penable;
  assign ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
  always_ff @(posedge core_clk) begin
    if (rst) mode <= 3'h0;
    else if (ctrl_wr && pready) mode <= pwdata[2:0];
  end
  // mode-dependent output checks wait until the pin synchronisers have refilled; complement checks run every cycle
  always_ff @(posedge core_clk) begin
    if (rst || ctrl_wr) held <= 3'h0;
    else if (held != 3'h7) held <= held + 3'h1;
  end
  a_comp_a: assert property (track_a_n == !track_a) else $error("track a complement");
  a_comp_b: assert property (track_b_n == !track_b) else $error("track b complement");
  a_comp_zero: assert property (zero_track_n == !zero_track) else $error("zero complement");
  a_one_step: assert property ((mode < 3'h4 && held == 3'h7) |->
    !($changed(track_a) && $changed(track_b))) else $error("two tracks moved at once");
  a_pass_enc: assert property ((mode == 3'h4 && held == 3'h7) |->
    {zero_track, track_b, track_a} == $past(encoder_input_terminal, 3)) else $error("enc pass");
  a_pass_freq: assert property ((mode == 3'h5 && held == 3'h7) |->
    {zero_track, track_b, track_a} == $past(frequency_input_terminal, 3)) else $error("freq pass");
  a_ready_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(setup)) else $error("stray ready");
  a_err_unmapped: assert property ((setup && paddr > 12'h010) |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  a_err_mapped: assert property ((setup && paddr <= 12'h010 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped address refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  c_pass: cover property (mode == 3'h5 && held == 3'h7);
  c_err: cover property (pslverr);
  c_zero: cover property ($rose(zero_track));
  c_step: cover property ($changed(track_b));
endmodule // efo_props

bind efo_frequency_output_unit efo_props efo_props_inst (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .encoder_input_terminal, .frequency_input_terminal,
  .track_a, .track_a_n, .track_b, .track_b_n, .zero_track, .zero_track_n);

// [verification/efo_drive_counter.sv]
// Purpose: downstream counter that follows the quadrature tracks
// Assumes: at most one track change per clock
// Notes: a two-state jump is not counted, the checker flags it in modes 0 to 3
`timescale 1ns/1ps
module efo_drive_counter (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic track_a,
  input  wire logic track_b,
  input  wire logic zero_track,
  output int        pos_count,
  output int        zero_count
);
  logic [1:0] last_q;
  logic [1:0] step;
  logic       last_z;
  // gray index: states 00, 10, 11, 01 count upwards
  assign step = {track_b, track_a ^ track_b} - last_q;
  always @(posedge core_clk) begin
    if (rst) begin
      pos_count <= 0;
      zero_count <= 0;
    end else begin
      if (step == 2'h1) pos_count <= pos_count + 1;
      if (step == 2'h3) pos_count <= pos_count - 1;
      if (zero_track && !last_z) zero_count <= zero_count + 1;
    end
    last_q <= {track_b, track_a ^ track_b};
    last_z <= zero_track;
  end
endmodule // efo_drive_counter

// [verification/efo_frequency_output_unit_tb.sv]
// Purpose: self-checking bench of the frequency output unit
// Assumes: APB answers in its own time; only the watchdog ends a wait
// Notes: rates are judged over a window with two steps of slack
`timescale 1ns/1ps
module efo_frequency_output_unit_tb;
  logic        core_clk, rst, psel, penable, pwrite, pslverr, pready, err;
  logic        zero_pulse_arm, probe_terminal;
  logic        track_a, track_a_n, track_b, track_b_n, zero_track, zero_track_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] percent_setpoint_in, speed_setpoint_in, resolver_angle;
  logic [2:0]  encoder_input_terminal, frequency_input_terminal;
  int          fail_count, n_checks, cnt_pos, cnt_zero, p;
  int          incr [8] = '{256, 512, 1024, 2048, 4096, 4096, 4096, 4096};

  efo_frequency_output_unit efo_frequency_output_unit_inst (.core_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .percent_setpoint_in,
    .speed_setpoint_in, .zero_pulse_arm, .resolver_angle, .probe_terminal,
    .encoder_input_terminal, .frequency_input_terminal, .track_a, .track_a_n, .track_b,
    .track_b_n, .zero_track, .zero_track_n);
  efo_drive_counter efo_drive_counter_inst (.core_clk, .rst, .track_a, .track_b, .zero_track,
    .pos_count(cnt_pos), .zero_count(cnt_zero));

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'h1;
    do begin
      tick(1);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    tick(1);
  endtask

  // four transitions per increment, window of 3000 clocks at 200 MHz
  task automatic rate(input logic [2:0] sel, input int code, input longint rpm);
    longint d;
    apb(1'h1, 12'h000, {25'h0, 3'(code), 1'h0, sel});
    tick(16);
    p = cnt_pos;
    tick(3000);
    d = longint'(cnt_pos - p) - rpm * incr[code] * 12000 / (longint'(60) * 200000000);
    chk(32'(d <= 2 && d >= -2), 32'h1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(90000);
    fail_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hFDC43575));
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata, zero_pulse_arm, probe_terminal} = '0;
    {percent_setpoint_in, speed_setpoint_in, resolver_angle} = '0;
    {encoder_input_terminal, frequency_input_terminal} = '0;
    tick(2);
    rst <= 1'h0;
    tick(1);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h30);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'hBB8);
    apb(1'h0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    apb(1'h1, 12'h004, 32'h7530);
    percent_setpoint_in <= 16'h1388;
    rate(3'h0, 4, 5000 * 30000 / 10000);
    speed_setpoint_in <= 16'h7D00;
    for (int c = 0; c < 8; c++) rate(3'h1, c, 32000);
    speed_setpoint_in <= 16'h8300;
    rate(3'h1, 4, -32000);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd, 32'h8);
    $display("test rates done");
    apb(1'h1, 12'h000, 32'h2);
    repeat (3) begin
      resolver_angle <= 16'($urandom);
      tick(600);
      apb(1'h0, 12'h010, 32'h0);
      chk(rd, 32'(resolver_angle >> 6));
    end
    apb(1'h1, 12'h008, 32'h8000);
    resolver_angle <= 16'h8000;
    tick(600);
    chk({31'h0, zero_track}, 32'h1);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd, 32'h1);
    resolver_angle <= 16'h4000;
    tick(600);
    chk({31'h0, zero_track}, 32'h0);
    $display("test resolver done");
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, 12'h008, k ? 32'h8000 : 32'h0);
      apb(1'h1, 12'h000, 32'h2);
      resolver_angle <= k ? 16'h4000 : 16'h0;
      tick(600);
      apb(1'h1, 12'h000, 32'h3);
      zero_pulse_arm <= 1'h1;
      probe_terminal <= 1'h1;
      tick(8);
      p = cnt_zero;
      // 2.25 revolutions at half a step per clock
      repeat (4608) begin
        resolver_angle <= resolver_angle + 16'h20;
        tick(1);
      end
      tick(8);
      chk(32'(cnt_zero - p), k ? 32'h1 : 32'h2);
      probe_terminal <= 1'h0;
      zero_pulse_arm <= 1'h0;
    end
    $display("test zero pulse done");
    for (int m = 4; m < 6; m++) begin
      apb(1'h1, 12'h000, 32'(m));
      repeat (8) begin
        encoder_input_terminal <= 3'($urandom);
        frequency_input_terminal <= 3'($urandom);
        tick(6);
        chk(32'({zero_track, track_b, track_a}),
          32'(m == 4 ? encoder_input_terminal : frequency_input_terminal));
      end
    end
    $display("test pass-through done");
    finish_test();
  end
endmodule // efo_frequency_output_unit_tb
